// [segl_drive.sv]
// segment display drive control with AHB-Lite register slave
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "segl_map.svh"
`default_nettype none
module segl_drive
    import segl_pkg::*;
#(
    parameter int NUM_COLS    = `SEGL_NUM_COLS,
    parameter int HOLD_CYCLES = `SEGL_HOLD_CYCLES
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire logic                  hsel_i,
    input  wire logic [31:0]           haddr_i,
    input  wire logic [1:0]            htrans_i,
    input  wire logic                  hwrite_i,
    input  wire logic [2:0]            hsize_i,
    input  wire logic                  hready_i,
    input  wire logic [31:0]           hwdata_i,
    output logic      [31:0]           hrdata_o,
    output logic                       hreadyout_o,
    output logic                       hresp_o,
    input  wire logic                  sub_clk_i,
    input  wire logic                  sleep_i,
    input  wire logic                  idle_i,
    input  wire logic                  mcu_reset_i,
    input  wire logic                  wdt_reset_i,
    input  wire logic                  serial_programming_mode_i,
    output logic      [5:0]            backplane_lines_o,
    output logic      [2*NUM_COLS-1:0] pixel_column_lines_o,
    output logic                       line_drive_en_o,
    output logic                       charge_pump_on_o
);
    localparam int MEM_AW = $clog2(NUM_COLS + 1);
    localparam int HOLD_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [9:0] MEM_LAST = 10'(`SEGL_MEM_FIRST + NUM_COLS);
    localparam logic [MEM_AW-1:0] FIDX_LAST = MEM_AW'(NUM_COLS);
    localparam logic [2:0] DIV_LAST = 3'(`SEGL_SUB_DIV - 1);

    if (NUM_COLS < 1 || NUM_COLS > 117 || HOLD_CYCLES < 1)
    begin : g_chk
        $error("segl_drive parameters out of range");
    end

    //======================================================================
    // pin synchronisers
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic       sub_prev_reg;
    logic       sub_s;
    logic       sleep_s;
    logic       idle_s;
    logic       mcu_s;
    logic       wdt_s;
    logic       icp_s;

    assign {sub_s, sleep_s, idle_s, mcu_s, wdt_s, icp_s} = sync2_reg;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            sub_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= {sub_clk_i, sleep_i, idle_i, mcu_reset_i, wdt_reset_i,
                             serial_programming_mode_i};
            sync2_reg    <= sync1_reg;
            sub_prev_reg <= sub_s;
        end
    end

    //======================================================================
    // bus slave and control register
    logic [7:0]        ctrl_reg;
    logic [7:0]        ctrl_next;
    logic              wr_pend_reg;
    logic              wr_pend_next;
    logic [9:0]        wr_idx_reg;
    logic [9:0]        wr_idx_next;
    logic [1:0]        rd_stage_reg;
    logic [1:0]        rd_stage_next;
    logic [9:0]        rd_idx_reg;
    logic [9:0]        rd_idx_next;
    logic [31:0]       hrdata_reg;
    logic [31:0]       hrdata_next;
    logic              hready_reg;
    logic              hready_next;
    logic [9:0]        idx_in;
    logic              mem_we;
    logic [7:0]        mem_bus_rd;
    logic [7:0]        mem_scan_rd;
    logic [7:0]        stat_byte;
    logic [7:0]        mem_mask;
    logic [MEM_AW-1:0] fidx_reg;
    logic              disp_rst;
    logic              floating;
    logic [1:0]        show_slot_reg;
    logic              show_pol_reg;

    assign idx_in = (haddr_i[31:12] == '0) ? haddr_i[11:2] : `SEGL_IDX_NONE;
    assign mem_we = wr_pend_reg && wr_idx_reg >= `SEGL_MEM_FIRST && wr_idx_reg <= MEM_LAST;
    assign mem_mask = ctrl_reg[`SEGL_DUTY_BIT] ? `SEGL_MASK_DUTY2 : `SEGL_MASK_DUTY3;
    assign stat_byte = {3'h0, show_pol_reg, show_slot_reg, charge_pump_on_o, ~disp_rst};

    always_comb
    begin
        ctrl_next     = ctrl_reg;
        wr_pend_next  = 1'b0;
        wr_idx_next   = wr_idx_reg;
        rd_stage_next = rd_stage_reg;
        rd_idx_next   = rd_idx_reg;
        hrdata_next   = hrdata_reg;
        hready_next   = hready_reg;
        if (wr_pend_reg && wr_idx_reg == `SEGL_CTRL_IDX)
        begin
            ctrl_next = hwdata_i[7:0] & `SEGL_CTRL_MASK;
        end
        if (rd_stage_reg == 2'h1)
        begin
            rd_stage_next = 2'h2;
        end
        else if (rd_stage_reg == 2'h2)
        begin
            rd_stage_next = 2'h0;
            hready_next   = 1'b1;
            if (rd_idx_reg == `SEGL_CTRL_IDX)
                hrdata_next = {24'h0, ctrl_reg};
            else if (rd_idx_reg == `SEGL_STAT_IDX)
                hrdata_next = {24'h0, stat_byte};
            else if (rd_idx_reg >= `SEGL_MEM_FIRST && rd_idx_reg <= MEM_LAST)
                hrdata_next = {24'h0, mem_bus_rd & mem_mask};
            else
                hrdata_next = 32'h0;
        end
        else if (hsel_i && htrans_i[1] && hready_i)
        begin
            if (hwrite_i)
            begin
                wr_pend_next = 1'b1;
                wr_idx_next  = idx_in;
            end
            else
            begin
                rd_stage_next = 2'h1;
                rd_idx_next   = idx_in;
                hready_next   = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            ctrl_reg     <= `SEGL_CTRL_RST;
            wr_pend_reg  <= 1'b0;
            wr_idx_reg   <= `SEGL_IDX_NONE;
            rd_stage_reg <= 2'h0;
            rd_idx_reg   <= `SEGL_IDX_NONE;
            hrdata_reg   <= 32'h0;
            hready_reg   <= 1'b1;
        end
        else
        begin
            ctrl_reg     <= ctrl_next;
            wr_pend_reg  <= wr_pend_next;
            wr_idx_reg   <= wr_idx_next;
            rd_stage_reg <= rd_stage_next;
            rd_idx_reg   <= rd_idx_next;
            hrdata_reg   <= hrdata_next;
            hready_reg   <= hready_next;
        end
    end

    assign hrdata_o    = hrdata_reg;
    assign hreadyout_o = hready_reg;
    assign hresp_o     = 1'b0;

    // bus reads one cycle after the write edge, so a read right behind a write sees it
    segl_mem #(
        .DATA_W (8),
        .DEPTH  (NUM_COLS + 1),
        .ADDR_W (MEM_AW)
    ) u_mem (
        .clk_i     (clk_i),
        .we_i      (mem_we),
        .waddr_i   (MEM_AW'(wr_idx_reg - `SEGL_MEM_FIRST)),
        .wdata_i   (hwdata_i[7:0]),
        .raddr_a_i (MEM_AW'(rd_idx_reg - `SEGL_MEM_FIRST)),
        .rdata_a_o (mem_bus_rd),
        .raddr_b_i (fidx_reg),
        .rdata_b_o (mem_scan_rd)
    );

    //======================================================================
    // reset conditions and float hold
    logic [HOLD_W-1:0] hold_reg;
    logic [HOLD_W-1:0] hold_next;
    logic              dev_rst;

    assign dev_rst  = mcu_s | (wdt_s & ~(idle_s | sleep_s));
    assign disp_rst = ~ctrl_reg[`SEGL_EN_BIT] | sleep_s | icp_s;
    assign floating = dev_rst | (hold_reg != '0);

    always_comb
    begin
        hold_next = hold_reg;
        if (dev_rst)
            hold_next = HOLD_W'(HOLD_CYCLES);
        else if (hold_reg != '0)
            hold_next = hold_reg - 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            hold_reg <= '0;
        else
            hold_reg <= hold_next;
    end

    //======================================================================
    // frame timing and memory scan
    segl_scan_type     state_reg;
    segl_scan_type     state_next;
    logic [2:0]        div_reg;
    logic [2:0]        div_next;
    logic [1:0]        slot_reg;
    logic [1:0]        slot_next;
    logic              pol_reg;
    logic              pol_next;
    logic [MEM_AW-1:0] fidx_next;
    logic              cap_v_reg;
    logic              cap_v_next;
    logic [MEM_AW-1:0] cap_idx_reg;
    logic [MEM_AW-1:0] cap_idx_next;
    logic [NUM_COLS:0] fetch_reg;
    logic [NUM_COLS:0] fetch_next;
    logic [NUM_COLS:0] show_reg;
    logic [NUM_COLS:0] show_next;
    logic [1:0]        show_slot_next;
    logic              show_pol_next;
    logic [1:0]        slot_last;
    logic              tick;

    assign slot_last = ctrl_reg[`SEGL_DUTY_BIT] ? `SEGL_SLOT_LAST2 : `SEGL_SLOT_LAST3;
    assign tick = sub_s & ~sub_prev_reg & (div_reg == DIV_LAST);

    always_comb
    begin
        state_next     = state_reg;
        div_next       = div_reg;
        slot_next      = slot_reg;
        pol_next       = pol_reg;
        fidx_next      = fidx_reg;
        cap_v_next     = 1'b0;
        cap_idx_next   = cap_idx_reg;
        fetch_next     = fetch_reg;
        show_next      = show_reg;
        show_slot_next = show_slot_reg;
        show_pol_next  = show_pol_reg;
        if (sub_s && !sub_prev_reg)
            div_next = div_reg + 1'b1;
        if (cap_v_reg)
            fetch_next[cap_idx_reg] = mem_scan_rd[slot_reg];
        case (state_reg)
            SCAN_IDLE:
            begin
                if (tick)
                begin
                    fidx_next  = '0;
                    state_next = SCAN_READ;
                    if (ctrl_reg[`SEGL_TYPE_BIT])
                    begin
                        slot_next = (slot_reg >= slot_last) ? 2'h0 : slot_reg + 1'b1;
                        if (slot_reg >= slot_last)
                            pol_next = ~pol_reg;
                    end
                    else if (!pol_reg)
                    begin
                        pol_next = 1'b1;
                    end
                    else
                    begin
                        pol_next  = 1'b0;
                        slot_next = (slot_reg >= slot_last) ? 2'h0 : slot_reg + 1'b1;
                    end
                end
            end
            SCAN_READ:
            begin
                cap_v_next   = 1'b1;
                cap_idx_next = fidx_reg;
                if (fidx_reg == FIDX_LAST)
                    state_next = SCAN_COMMIT;
                else
                    fidx_next = fidx_reg + 1'b1;
            end
            SCAN_COMMIT:
            begin
                // slot, polarity and bits change together so no mixed slot is shown
                show_next      = fetch_next;
                show_slot_next = slot_reg;
                show_pol_next  = pol_reg;
                state_next     = SCAN_IDLE;
            end
            default:
            begin
                state_next = SCAN_IDLE;
            end
        endcase
        if (disp_rst || floating)
        begin
            state_next = SCAN_IDLE;
            div_next   = 3'h0;
            slot_next  = 2'h0;
            pol_next   = 1'b0;
            cap_v_next = 1'b0;
            {show_next, show_slot_next, show_pol_next} = '0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state_reg     <= SCAN_IDLE;
            div_reg       <= 3'h0;
            slot_reg      <= 2'h0;
            pol_reg       <= 1'b0;
            fidx_reg      <= '0;
            cap_v_reg     <= 1'b0;
            cap_idx_reg   <= '0;
            fetch_reg     <= '0;
            show_reg      <= '0;
            show_slot_reg <= 2'h0;
            show_pol_reg  <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            div_reg       <= div_next;
            slot_reg      <= slot_next;
            pol_reg       <= pol_next;
            fidx_reg      <= fidx_next;
            cap_v_reg     <= cap_v_next;
            cap_idx_reg   <= cap_idx_next;
            fetch_reg     <= fetch_next;
            show_reg      <= show_next;
            show_slot_reg <= show_slot_next;
            show_pol_reg  <= show_pol_next;
        end
    end

    //======================================================================
    // line levels, half bias
    logic [5:0]            bp_next;
    logic [2*NUM_COLS-1:0] col_next;
    logic [5:0]            bp_reg;
    logic [2*NUM_COLS-1:0] col_reg;
    logic                  drive_en_reg;
    logic                  pump_reg;

    for (genvar c = 0; c < NUM_COLS; c++)
    begin : g_col
        // column swings two levels: opposite of the active backplane when lit
        assign col_next[2*c +: 2] = (disp_rst || floating) ? `SEGL_LVL_GND :
            ((show_reg[c] ~^ show_pol_reg) ? `SEGL_LVL_HIGH : `SEGL_LVL_GND);
    end

    for (genvar b = 0; b < 3; b++)
    begin : g_bp
        if (b == `SEGL_THIRD_BP)
        begin : g_third
            assign bp_next[2*b +: 2] = (disp_rst || floating) ? `SEGL_LVL_GND :
                ctrl_reg[`SEGL_DUTY_BIT] ?
                ((show_reg[NUM_COLS] ~^ show_pol_reg) ? `SEGL_LVL_HIGH : `SEGL_LVL_GND) :
                (show_slot_reg == 2'(b)) ?
                (show_pol_reg ? `SEGL_LVL_GND : `SEGL_LVL_HIGH) : `SEGL_LVL_MID;
        end
        else
        begin : g_plain
            assign bp_next[2*b +: 2] = (disp_rst || floating) ? `SEGL_LVL_GND :
                (show_slot_reg == 2'(b)) ?
                (show_pol_reg ? `SEGL_LVL_GND : `SEGL_LVL_HIGH) : `SEGL_LVL_MID;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            bp_reg       <= '0;
            col_reg      <= '0;
            drive_en_reg <= 1'b0;
            pump_reg     <= 1'b0;
        end
        else
        begin
            bp_reg       <= bp_next;
            col_reg      <= col_next;
            drive_en_reg <= ~floating;
            pump_reg     <= ctrl_reg[`SEGL_PUMP_BIT] | icp_s;
        end
    end

    assign backplane_lines_o    = bp_reg;
    assign pixel_column_lines_o = col_reg;
    assign line_drive_en_o      = drive_en_reg;
    assign charge_pump_on_o     = pump_reg;
endmodule
`default_nettype wire

// [segl_drive_asserts.sv]
// checker bound to the ports of the segment display driver
`timescale 1ns/1ps
`default_nettype none
module segl_drive_asserts #(
    parameter int NUM_COLS    = 21,
    parameter int HOLD_CYCLES = 4
) (
    input wire logic                  clk_i,
    input wire logic                  srst_i,
    input wire logic                  hsel_i,
    input wire logic [1:0]            htrans_i,
    input wire logic                  hwrite_i,
    input wire logic                  hready_i,
    input wire logic                  hreadyout_o,
    input wire logic                  sleep_i,
    input wire logic                  idle_i,
    input wire logic                  mcu_reset_i,
    input wire logic                  wdt_reset_i,
    input wire logic                  serial_programming_mode_i,
    input wire logic [5:0]            backplane_lines_o,
    input wire logic [2*NUM_COLS-1:0] pixel_column_lines_o,
    input wire logic                  line_drive_en_o,
    input wire logic                  charge_pump_on_o
);
    //==========
    // run counters, saturating so long quiet spans never wrap
    logic [9:0] blank_reg;
    logic [9:0] blank_next;
    logic [9:0] calm_reg;
    logic [9:0] calm_next;
    logic       dev_rst;
    assign dev_rst = mcu_reset_i || (wdt_reset_i && !idle_i && !sleep_i);
    always_comb
    begin
        blank_next = 10'h000;
        calm_next  = 10'h000;
        if (sleep_i || serial_programming_mode_i)
            blank_next = blank_reg + {9'h000, blank_reg != 10'h3ff};
        if (!dev_rst)
            calm_next = calm_reg + {9'h000, calm_reg != 10'h3ff};
    end
    always_ff @(posedge clk_i)
    begin
        blank_reg <= srst_i ? 10'h000 : blank_next;
        calm_reg  <= srst_i ? 10'h000 : calm_next;
    end
    //==========
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    read_wait_a: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i
        |=> !hreadyout_o [*2] ##1 hreadyout_o) else $error("read wait not two cycles");
    write_ready_a: assert property (hsel_i && htrans_i[1] && hready_i && hwrite_i
        |=> hreadyout_o) else $error("write data phase stalled");
    pump_prog_a: assert property (serial_programming_mode_i [*5] |-> charge_pump_on_o)
        else $error("pump off while programming");
    blank_lines_a: assert property (blank_reg >= 10'd40 |->
        backplane_lines_o == 6'h00 && pixel_column_lines_o == '0) else $error("lines not low");
    dev_float_a: assert property (mcu_reset_i [*4] |-> !line_drive_en_o)
        else $error("lines driven in device reset");
    wdt_float_a: assert property ((wdt_reset_i && !idle_i && !sleep_i) [*4] |->
        !line_drive_en_o) else $error("lines driven in watchdog reset");
    hold_float_a: assert property ($fell(mcu_reset_i) |=> !line_drive_en_o [*4])
        else $error("float ended too early");
    drive_back_a: assert property (calm_reg > HOLD_CYCLES + 8 |-> line_drive_en_o)
        else $error("lines still floating");
endmodule
bind segl_drive segl_drive_asserts #(
    .NUM_COLS    (NUM_COLS),
    .HOLD_CYCLES (HOLD_CYCLES)
) u_chk (
    .clk_i, .srst_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hreadyout_o, .sleep_i,
    .idle_i, .mcu_reset_i, .wdt_reset_i, .serial_programming_mode_i, .backplane_lines_o,
    .pixel_column_lines_o, .line_drive_en_o, .charge_pump_on_o
);
`default_nettype wire

// [segl_drive_tb_top.sv]
// self-checking bench for the segment display driver
`timescale 1ns/1ps
`include "segl_map.svh"
`default_nettype none
module segl_drive_tb_top import segl_pkg::*;;
    localparam int NC   = 21;
    localparam int HOLD = 4;
    localparam int SUBH = 20;
    logic        clk_i = 1'b0;
    logic        srst_i, hsel_i, hwrite_i, sub_clk_i, sleep_i, idle_i, mcu_reset_i;
    logic        wdt_reset_i, serial_programming_mode_i, hreadyout_o, hresp_o;
    logic        line_drive_en_o, charge_pump_on_o;
    logic [1:0]  htrans_i, act;
    logic [2:0]  hsize_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [5:0]  backplane_lines_o;
    logic [41:0] pixel_column_lines_o;
    logic [1:0]  lvl;
    logic [21:0] lit;
    int          err_count, comparisons, sub_cnt, seed;
    int          mem[22];
    segl_drive #(.NUM_COLS(NC), .HOLD_CYCLES(HOLD)) u_dut (
        .clk_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hready_i(hreadyout_o), .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .sub_clk_i,
        .sleep_i, .idle_i, .mcu_reset_i, .wdt_reset_i, .serial_programming_mode_i,
        .backplane_lines_o, .pixel_column_lines_o, .line_drive_en_o, .charge_pump_on_o);
    segl_panel_model #(.NUM_COLS(NC)) u_panel (.bp_i(backplane_lines_o),
        .col_i(pixel_column_lines_o), .drive_en_i(line_drive_en_o), .act_o(act),
        .lvl_o(lvl), .lit_o(lit));
    always #2.5 clk_i = ~clk_i;
    // sub clock tied to the bench clock so tick spacing is exact
    always @(posedge clk_i)
    begin
        sub_cnt <= (sub_cnt == SUBH - 1) ? 0 : sub_cnt + 1;
        if (sub_cnt == SUBH - 1)
            sub_clk_i <= ~sub_clk_i;
    end
    //==========
    // tasks
    task automatic stop_test();
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_disp(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
        chk_disp({32'h0, got}, {32'h0, exp});
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    function automatic logic [31:0] ba(input logic [9:0] i);
        return {20'h0, i, 2'b00};
    endfunction
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= a;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk_disp({hresp_o, r & m}, {1'b0, e});
    endtask
    task automatic run_disp(input logic [7:0] c, input int ticks);
        int slot, pol, last, n;
        logic [5:0] prev;
        logic [21:0] e;
        wr(ba(`SEGL_CTRL_IDX), 32'h0);
        tk(10);
        wr(ba(`SEGL_CTRL_IDX), {24'h0, c});
        slot = 0;
        pol = 0;
        last = c[1] ? 1 : 2;
        tk(3);
        prev = backplane_lines_o;
        for (int t = 0; t < ticks; t++)
        begin
            n = 0;
            do begin @(posedge clk_i); n++; end while (backplane_lines_o === prev && n < 1000);
            prev = backplane_lines_o;
            if (c[7])
            begin
                slot = (slot == last) ? 0 : slot + 1;
                pol = (slot == 0) ? 1 - pol : pol;
            end
            else
            begin
                pol = 1 - pol;
                slot = (pol == 0) ? ((slot == last) ? 0 : slot + 1) : slot;
            end
            for (int k = 0; k < 22; k++)
                e[k] = (k < NC || c[1]) ? mem[k][slot] : 1'b0;
            chk_disp({act, lvl, lit}, {slot[1:0], pol ? 2'h0 : 2'h2, e});
            if (t > 0)
                chk_disp(n, 2 * SUBH * `SEGL_SUB_DIV);
        end
    endtask
    //==========
    // main sequence
    initial
    begin
        {srst_i, hsel_i, hwrite_i, sub_clk_i, sleep_i, idle_i, mcu_reset_i} = 7'h40;
        {wdt_reset_i, serial_programming_mode_i, htrans_i} = 4'h0;
        {haddr_i, hwdata_i, sub_cnt, err_count, comparisons} = '0;
        hsize_i = 3'h2;
        seed = $urandom(32'h627b);
        tk(2);
        srst_i <= 1'b0;
        rd_chk(ba(`SEGL_CTRL_IDX), 32'hffffffff, 32'h0);
        rd_chk(ba(`SEGL_STAT_IDX), 32'h3, 32'h0);
        wr(32'h100, 32'hffffffff);
        rd_chk(32'h100, 32'hffffffff, 32'h0);
        wr(ba(`SEGL_CTRL_IDX), 32'hffffffff);
        rd_chk(ba(`SEGL_CTRL_IDX), 32'hffffffff, 32'h87);
        tk(3);
        chk_bus(charge_pump_on_o, 1);
        wr(ba(`SEGL_CTRL_IDX), 32'h0);
        tk(3);
        chk_bus(charge_pump_on_o, 0);
        for (int k = 0; k < 22; k++)
        begin
            mem[k] = $urandom & 32'hff;
            wr(ba(`SEGL_MEM_FIRST + 10'(k)), mem[k]);
        end
        for (int k = 0; k < 22; k++)
            rd_chk(ba(`SEGL_MEM_FIRST + 10'(k)), 32'hffffffff, mem[k] & 7);
        foreach (mem[i])
            if (i < 4)
                run_disp(8'h05 | (i[0] ? 8'h80 : 8'h00) | (i[1] ? 8'h02 : 8'h00), 8);
        rd_chk(ba(`SEGL_MEM_FIRST), 32'hffffffff, mem[0] & 3);
        rd_chk(ba(`SEGL_STAT_IDX), 32'h3, 32'h3);
        sleep_i <= 1'b1;
        tk(40);
        chk_disp({line_drive_en_o, backplane_lines_o, pixel_column_lines_o}, 64'h1 << 48);
        rd_chk(ba(`SEGL_STAT_IDX), 32'h1, 32'h0);
        sleep_i <= 1'b0;
        wr(ba(`SEGL_CTRL_IDX), 32'h1);
        serial_programming_mode_i <= 1'b1;
        tk(40);
        chk_disp({charge_pump_on_o, backplane_lines_o, pixel_column_lines_o}, 64'h1 << 48);
        rd_chk(ba(`SEGL_STAT_IDX), 32'h1f, 32'h2);
        serial_programming_mode_i <= 1'b0;
        wr(ba(`SEGL_CTRL_IDX), 32'h5);
        {idle_i, wdt_reset_i} <= 2'h3;
        tk(40);
        chk_bus(line_drive_en_o, 1);
        idle_i <= 1'b0;
        tk(10);
        chk_bus(line_drive_en_o, 0);
        wdt_reset_i <= 1'b0;
        tk(40);
        mcu_reset_i <= 1'b1;
        tk(10);
        chk_bus(line_drive_en_o, 0);
        mcu_reset_i <= 1'b0;
        tk(2);
        chk_bus(line_drive_en_o, 0);
        tk(HOLD + 10);
        chk_bus(line_drive_en_o, 1);
        rd_chk(ba(`SEGL_CTRL_IDX), 32'hff, 32'h5);
        stop_test();
    end
    // watchdog: about five times the expected run length
    initial
    begin
        #300000;
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire

// [segl_map.svh]
// register map, field positions and timing constants of the segment display driver
//==========================================================================
`ifndef SEGL_MAP_SVH
`define SEGL_MAP_SVH

//==========================================================================
// register indexes, byte address is four times the index
`define SEGL_CTRL_IDX      10'h000
`define SEGL_STAT_IDX      10'h001
`define SEGL_MEM_FIRST     10'h080
`define SEGL_IDX_NONE      10'h3ff

//==========================================================================
// control fields
`define SEGL_TYPE_BIT      7
`define SEGL_PUMP_BIT      2
`define SEGL_DUTY_BIT      1
`define SEGL_EN_BIT        0
`define SEGL_CTRL_RST      8'h00
`define SEGL_CTRL_MASK     8'h87
`define SEGL_MASK_DUTY3    8'h07
`define SEGL_MASK_DUTY2    8'h03

//==========================================================================
// scan and levels
`define SEGL_NUM_COLS      21
`define SEGL_SUB_DIV       8
`define SEGL_SLOT_LAST3    2'h2
`define SEGL_SLOT_LAST2    2'h1
`define SEGL_THIRD_BP      2
`define SEGL_LVL_GND       2'h0
`define SEGL_LVL_MID       2'h1
`define SEGL_LVL_HIGH      2'h2

//==========================================================================
// timing
`define SEGL_CLK_MHZ       200
`define SEGL_RSTD_NS       1000
`define SEGL_SST_NS        1000
`define SEGL_HOLD_CYCLES   ((`SEGL_RSTD_NS + `SEGL_SST_NS) * `SEGL_CLK_MHZ / 1000)

`endif

// [segl_mem.sv]
// display memory with one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module segl_mem #(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 22,
    parameter int ADDR_W = 5
) (
    input  wire logic              clk_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [ADDR_W-1:0] raddr_a_i,
    output logic      [DATA_W-1:0] rdata_a_o,
    input  wire logic [ADDR_W-1:0] raddr_b_i,
    output logic      [DATA_W-1:0] rdata_b_o
);
    //======================================================================
    // storage, left unreset: contents are undefined after power-on
    logic [DATA_W-1:0] mem_reg [DEPTH];

    if (DEPTH < 1 || DEPTH > (1 << ADDR_W))
    begin : g_chk
        $error("segl_mem depth does not fit address width");
    end

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_a_o <= mem_reg[raddr_a_i];
        rdata_b_o <= mem_reg[raddr_b_i];
    end
endmodule
`default_nettype wire

// [segl_panel_model.sv]
// passive segment panel: decodes drive levels into the lit pixels of the active slot
`timescale 1ns/1ps
`default_nettype none
module segl_panel_model
    import segl_pkg::*;
#(
    parameter int NUM_COLS = 21
) (
    input  wire logic [5:0]            bp_i,
    input  wire logic [2*NUM_COLS-1:0] col_i,
    input  wire logic                  drive_en_i,
    output logic      [1:0]            act_o,
    output segl_level_type             lvl_o,
    output logic      [NUM_COLS:0]     lit_o
);
    // floating glass shows nothing, so undriven lines light no pixel
    always_comb
    begin
        act_o = 2'h3;
        lvl_o = 2'h1;
        for (int b = 2; b >= 0; b--)
        begin
            if (drive_en_i && bp_i[2*b+:2] != 2'h1)
            begin
                act_o = 2'(b);
                lvl_o = bp_i[2*b+:2];
            end
        end
        for (int c = 0; c < NUM_COLS; c++)
            lit_o[c] = drive_en_i && col_i[2*c+:2] != 2'h1 && col_i[2*c+:2] != lvl_o;
        lit_o[NUM_COLS] = drive_en_i && act_o != 2'h2 && bp_i[5:4] != 2'h1
            && bp_i[5:4] != lvl_o;
    end
endmodule
`default_nettype wire

// [segl_pkg.sv]
// types shared by the segment display driver
`default_nettype none
package segl_pkg;
    typedef enum logic [1:0] {SCAN_IDLE, SCAN_READ, SCAN_COMMIT} segl_scan_type;
    typedef logic [1:0] segl_level_type;
endpackage
`default_nettype wire
